/* hw/afc_clock_gen.sv */
// Field-locked audio master clock synthesizer with bit/channel clock dividers.
// Assumes clock_i is the crystal reference; references and divider input are pins.
// Overview of operation
// [RULE1] Master clock synthesized from the crystal reference clock.
// [RULE2] Master clock held to a fixed count of clocks per video field.
// [RULE3] Loop correction moves one step per field, never abruptly.
// [RULE4] 18-bit clocks-per-field target in three byte registers, set by software.
// [RULE5] 22-bit nominal increment in three byte registers, set by software.
// [RULE6] Divider chain clocked from the separate divider input pin.
// [RULE7] Bit clock is divider input over twice (divider value plus one).
// [RULE8] Channel clock is bit clock over twice the channel divider value.
// [RULE9] Control bits open the loop and pick external vertical reference.
// [RULE10] Channel clock phase bit picks falling (0) or rising (1) bit clock edges.
// [RULE11] Bit clock phase bit picks falling (0) or rising (1) input edges.
// [RULE12] Crystal selection strapped at reset; software computes increment for it.
// [RULE13] Controller writes registers by subaddress over the serial bus.
// [RULE14] Open loop: accumulator steps by nominal increment, no correction.
// [RULE15] Closed loop: count clocks per field, compare, nudge increment slowly.
module afc_clock_gen #(
  parameter int CORR_W = 12,
  parameter logic [6:0] DEV_ADDR = afc_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Serial control bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Field references and strap
  input wire logic field_ref_int_i,
  input wire logic field_ref_ext_i,
  input wire logic xtal_sel_strap_i,
  // Audio clocks
  input wire logic divider_clock_in_i,
  output logic synth_master_clock_out_o,
  output logic serial_bit_clock_out_o,
  output logic channel_select_clock_out_o
);
  localparam logic signed [CORR_W-1:0] CORR_MAX = {1'b0, {(CORR_W-1){1'b1}}};
  localparam logic signed [CORR_W-1:0] CORR_MIN = {1'b1, {(CORR_W-1){1'b0}}};
  localparam int AW = afc_pkg::ACC_W;

  afc_reg_if bus_if();

  afc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .bus(bus_if.slave)
  );

  logic [afc_pkg::CPF_W-1:0] cpf_q, cpf_d;
  logic [afc_pkg::NI_W-1:0] ni_q, ni_d;
  logic [afc_pkg::DIV_W-1:0] bdiv_q, bdiv_d, cdiv_q, cdiv_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic loop_open, bit_ph, ch_ph;

  assign loop_open = ctrl_q[afc_pkg::CTRL_LOOP_OPEN];
  assign bit_ph = ctrl_q[afc_pkg::CTRL_BIT_PHASE];
  assign ch_ph = ctrl_q[afc_pkg::CTRL_CH_PHASE];

  // [RULE4] [RULE5] byte-wise register writes
  always_comb begin
    cpf_d = cpf_q;
    ni_d = ni_q;
    bdiv_d = bdiv_q;
    cdiv_d = cdiv_q;
    ctrl_d = ctrl_q;
    if (bus_if.wr_stb) begin
      case (bus_if.waddr)
        afc_pkg::SUB_CPF_LO: cpf_d[7:0] = bus_if.wdata;
        afc_pkg::SUB_CPF_MID: cpf_d[15:8] = bus_if.wdata;
        afc_pkg::SUB_CPF_HI: cpf_d[17:16] = bus_if.wdata[1:0];
        afc_pkg::SUB_NI_LO: ni_d[7:0] = bus_if.wdata;
        afc_pkg::SUB_NI_MID: ni_d[15:8] = bus_if.wdata;
        afc_pkg::SUB_NI_HI: ni_d[21:16] = bus_if.wdata[5:0];
        afc_pkg::SUB_BIT_DIV: bdiv_d = bus_if.wdata[5:0];
        afc_pkg::SUB_CH_DIV: cdiv_d = bus_if.wdata[5:0];
        afc_pkg::SUB_CTRL: ctrl_d = bus_if.wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpf_q <= '0;
      ni_q <= '0;
      bdiv_q <= '0;
      cdiv_q <= '0;
      ctrl_q <= '0;
    end else begin
      cpf_q <= cpf_d;
      ni_q <= ni_d;
      bdiv_q <= bdiv_d;
      cdiv_q <= cdiv_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Strap and vertical reference pins
  logic xs1_q, xs2_q, xtal_sel_q, xtal_sel_d, vx1_q, vx2_q, vref_prev_q, vref, field_ev;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic locked_q, locked_d;

  // [RULE12] sample strap once synchroniser has settled
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    xtal_sel_d = xtal_sel_q;
    if (strap_cnt_q != 2'h3) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
    end
    if (strap_cnt_q == afc_pkg::STRAP_SAMPLE_CNT) begin
      xtal_sel_d = xs2_q;
    end
  end

  // [RULE9] vertical reference select
  assign vref = ctrl_q[afc_pkg::CTRL_VREF_EXT] ? vx2_q : field_ref_int_i;
  assign field_ev = vref & ~vref_prev_q;

  // Register readback, status shows strap and lock
  always_comb begin
    case (bus_if.raddr)
      afc_pkg::SUB_CPF_LO: bus_if.rdata = afc_pkg::afc_byte({6'h00, cpf_q}, 2'h0);
      afc_pkg::SUB_CPF_MID: bus_if.rdata = afc_pkg::afc_byte({6'h00, cpf_q}, 2'h1);
      afc_pkg::SUB_CPF_HI: bus_if.rdata = afc_pkg::afc_byte({6'h00, cpf_q}, 2'h2);
      afc_pkg::SUB_NI_LO: bus_if.rdata = afc_pkg::afc_byte({2'h0, ni_q}, 2'h0);
      afc_pkg::SUB_NI_MID: bus_if.rdata = afc_pkg::afc_byte({2'h0, ni_q}, 2'h1);
      afc_pkg::SUB_NI_HI: bus_if.rdata = afc_pkg::afc_byte({2'h0, ni_q}, 2'h2);
      afc_pkg::SUB_BIT_DIV: bus_if.rdata = {2'h0, bdiv_q};
      afc_pkg::SUB_CH_DIV: bus_if.rdata = {2'h0, cdiv_q};
      afc_pkg::SUB_CTRL: bus_if.rdata = {4'h0, ctrl_q};
      afc_pkg::SUB_STATUS: bus_if.rdata = {6'h00, xtal_sel_q, locked_q};
      default: bus_if.rdata = 8'h00;
    endcase
  end

  // Synthesizer and lock loop
  logic [AW-1:0] acc_q, acc_d, inc;
  logic signed [CORR_W-1:0] corr_q, corr_d;
  logic [afc_pkg::CPF_W-1:0] fcnt_q, fcnt_d;
  logic mrise;

  always_comb begin
    // [RULE14] open loop uses bare nominal step
    inc = loop_open ? {1'b0, ni_q}
                    : AW'({1'b0, ni_q} + {{(AW-CORR_W){corr_q[CORR_W-1]}}, corr_q});
    // [RULE1] phase accumulator on crystal clock
    acc_d = acc_q + inc;
    mrise = acc_d[AW-1] & ~acc_q[AW-1];
    fcnt_d = fcnt_q;
    corr_d = corr_q;
    locked_d = locked_q;
    // [RULE2] count master clocks per field
    if (field_ev) begin
      fcnt_d = {{(afc_pkg::CPF_W-1){1'b0}}, mrise};
      locked_d = (fcnt_q == cpf_q);
    end else if (mrise && fcnt_q != {afc_pkg::CPF_W{1'b1}}) begin
      fcnt_d = fcnt_q + 1'b1;
    end
    // [RULE15] [RULE3] one-step nudge per field
    if (loop_open) begin
      corr_d = '0;
    end else if (field_ev) begin
      if (fcnt_q < cpf_q && corr_q != CORR_MAX) begin
        corr_d = corr_q + 1'b1;
      end else if (fcnt_q > cpf_q && corr_q != CORR_MIN) begin
        corr_d = corr_q - 1'b1;
      end
    end
  end

  // Divider chain
  logic [2:0] dx_q;
  logic [afc_pkg::DIV_W-1:0] scnt_q, scnt_d, lcnt_q, lcnt_d;
  logic bclk_q, bclk_d, lr_q, lr_d, div_rise, div_fall, div_ev, bclk_ev, lr_ev;

  // [RULE6] divider input through two-stage synchroniser
  assign div_rise = dx_q[1] & ~dx_q[2];
  assign div_fall = ~dx_q[1] & dx_q[2];
  // [RULE11] input edge select
  assign div_ev = bit_ph ? div_rise : div_fall;
  assign bclk_ev = div_ev && (scnt_q >= bdiv_q);
  // [RULE10] bit clock edge select
  assign lr_ev = bclk_ev && ((~bclk_q) == ch_ph);

  always_comb begin
    scnt_d = scnt_q;
    bclk_d = bclk_q;
    lcnt_d = lcnt_q;
    lr_d = lr_q;
    // [RULE7] half period of divider value plus one
    if (bclk_ev) begin
      scnt_d = '0;
      bclk_d = ~bclk_q;
    end else if (div_ev) begin
      scnt_d = scnt_q + 1'b1;
    end
    // [RULE8] zero channel divider holds the clock
    if (lr_ev && cdiv_q != '0) begin
      if (lcnt_q >= cdiv_q - 1'b1) begin
        lcnt_d = '0;
        lr_d = ~lr_q;
      end else begin
        lcnt_d = lcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xtal_sel_q <= 1'b0;
      strap_cnt_q <= 2'h0;
      vx1_q <= 1'b0;
      vx2_q <= 1'b0;
      vref_prev_q <= 1'b0;
      locked_q <= 1'b0;
      acc_q <= '0;
      corr_q <= '0;
      fcnt_q <= '0;
      dx_q <= 3'h0;
      scnt_q <= '0;
      lcnt_q <= '0;
      bclk_q <= 1'b0;
      lr_q <= 1'b0;
    end else begin
      xs1_q <= xtal_sel_strap_i;
      xs2_q <= xs1_q;
      xtal_sel_q <= xtal_sel_d;
      strap_cnt_q <= strap_cnt_d;
      vx1_q <= field_ref_ext_i;
      vx2_q <= vx1_q;
      vref_prev_q <= vref;
      locked_q <= locked_d;
      acc_q <= acc_d;
      corr_q <= corr_d;
      fcnt_q <= fcnt_d;
      dx_q <= {dx_q[1:0], divider_clock_in_i};
      scnt_q <= scnt_d;
      lcnt_q <= lcnt_d;
      bclk_q <= bclk_d;
      lr_q <= lr_d;
    end
  end

  assign synth_master_clock_out_o = acc_q[AW-1];
  assign serial_bit_clock_out_o = bclk_q;
  assign channel_select_clock_out_o = lr_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_field_short;
    field_ev && !loop_open && (fcnt_q < cpf_q) && (corr_q != CORR_MAX);
  endsequence
  sequence s_wrong_edge;
    (bit_ph ? div_fall : div_rise) && !(bit_ph ? div_rise : div_fall);
  endsequence

  AST_CORR_UP: assert property (s_field_short |=> corr_q == $past(corr_q) + 1'b1) // [RULE15]
    else $error("correction did not step up on short field");
  AST_CORR_SLOW: assert property ($changed(corr_q) |-> $past(field_ev) || $past(loop_open)) // [RULE3]
    else $error("correction moved outside a field edge");
  AST_OPEN_NOCORR: assert property (loop_open |=> corr_q == '0) // [RULE14]
    else $error("correction kept with loop open");
  AST_OPEN_STEP: assert property (loop_open |=> acc_q == $past(acc_q) + $past(ni_q)) // [RULE14]
    else $error("open loop step differs from nominal");
  AST_LOCK_FLAG: assert property (field_ev |=> locked_q == ($past(fcnt_q) == $past(cpf_q))) // [RULE2]
    else $error("lock flag disagrees with field count");
  AST_BCLK_EDGE: assert property ($changed(bclk_q) |-> $past(div_ev) // [RULE7]
                                  && ($past(scnt_q) >= $past(bdiv_q)))
    else $error("bit clock toggled off its count");
  AST_BCLK_PHASE: assert property (s_wrong_edge |=> $stable(bclk_q)) // [RULE11]
    else $error("bit clock moved on unselected edge");
  AST_LR_EDGE: assert property ($changed(lr_q) |-> $past(bclk_ev) && (bclk_q == $past(ch_ph))) // [RULE10]
    else $error("channel clock moved on wrong bit clock edge");
  AST_LR_OFF: assert property (cdiv_q == '0 |=> $stable(lr_q)) // [RULE8]
    else $error("channel clock moved with zero divider");
  AST_CPF_WRITE: assert property (bus_if.wr_stb && bus_if.waddr == afc_pkg::SUB_CPF_LO // [RULE4]
                                  |=> cpf_q[7:0] == $past(bus_if.wdata))
    else $error("target low byte not written");
  AST_STRAP: assert property (strap_cnt_q == afc_pkg::STRAP_SAMPLE_CNT |=> xtal_sel_q == $past(xs2_q)) // [RULE12]
    else $error("strap not captured");
endmodule

/* hw/afc_i2c_slave.sv */
// Two-wire serial bus slave with subaddress auto-increment.
// Assumes scl/sda arrive asynchronously and are sampled well above bus rate.
module afc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = afc_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Register side
  afc_reg_if.slave bus
);
  logic [2:0] scl_q, sda_q;
  afc_pkg::afc_i2c_st_t st_q, st_d, ph_q, ph_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, sub_q, sub_d, wa_q, wa_d, wd_q, wd_d;
  logic out_q, out_d, oe_n_q, oe_n_d, wr_q, wr_d;
  logic scl_rise, scl_fall, start, stop;
  logic [7:0] byte_v;

  // Stage 0 feeds only stage 1
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start = ~sda_q[1] & sda_q[2] & scl_q[1];
  assign stop = sda_q[1] & ~sda_q[2] & scl_q[1];
  assign byte_v = {sh_q[6:0], sda_q[1]};

  // [RULE13] subaddressed writes
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sub_d = sub_q;
    wa_d = wa_q;
    wd_d = wd_q;
    out_d = out_q;
    oe_n_d = oe_n_q;
    wr_d = 1'b0;
    if (stop) begin
      st_d = afc_pkg::ST_IDLE;
      out_d = 1'b1;
      oe_n_d = 1'b1;
    end else if (start) begin
      st_d = afc_pkg::ST_ADDR;
      cnt_d = 3'h0;
      out_d = 1'b1;
      oe_n_d = 1'b1;
    end else if (scl_rise) begin
      cnt_d = cnt_q + 3'h1;
      unique case (st_q)
        afc_pkg::ST_IDLE: ;
        afc_pkg::ST_ADDR, afc_pkg::ST_SUB, afc_pkg::ST_WDATA: begin
          sh_d = byte_v;
          if (cnt_q == 3'h7) begin
            st_d = afc_pkg::ST_ACK;
            ph_d = afc_pkg::ST_WDATA;
            if (st_q == afc_pkg::ST_ADDR) begin
              ph_d = byte_v[0] ? afc_pkg::ST_RDATA : afc_pkg::ST_SUB;
              if (byte_v[7:1] != DEV_ADDR) begin
                st_d = afc_pkg::ST_IDLE;
              end
            end else if (st_q == afc_pkg::ST_SUB) begin
              sub_d = byte_v;
            end else begin
              wr_d = 1'b1;
              wa_d = sub_q;
              wd_d = byte_v;
              sub_d = sub_q + 8'h01;
            end
          end
        end
        afc_pkg::ST_ACK: begin
          st_d = ph_q;
          cnt_d = 3'h0;
          if (ph_q == afc_pkg::ST_RDATA) begin
            sh_d = bus.rdata;
          end
        end
        afc_pkg::ST_RDATA: begin
          sh_d = {sh_q[6:0], 1'b0};
          if (cnt_q == 3'h7) begin
            st_d = afc_pkg::ST_MACK;
            sub_d = sub_q + 8'h01;
          end
        end
        afc_pkg::ST_MACK: begin
          cnt_d = 3'h0;
          st_d = sda_q[1] ? afc_pkg::ST_IDLE : afc_pkg::ST_RDATA;
          sh_d = bus.rdata;
        end
      endcase
    end else if (scl_fall) begin
      // Change the drive when scl falls; start and stop only release it
      out_d = 1'b1;
      oe_n_d = 1'b1;
      if (st_q == afc_pkg::ST_ACK) begin
        out_d = 1'b0;
        oe_n_d = 1'b0;
      end else if (st_q == afc_pkg::ST_RDATA) begin
        out_d = sh_q[7];
        oe_n_d = sh_q[7];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      st_q <= afc_pkg::ST_IDLE;
      ph_q <= afc_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      sub_q <= 8'h00;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      out_q <= 1'b1;
      oe_n_q <= 1'b1;
      wr_q <= 1'b0;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sub_q <= sub_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      wr_q <= wr_d;
    end
  end

  assign sda_o = out_q;
  assign sda_oe_n_o = oe_n_q;
  assign bus.wr_stb = wr_q;
  assign bus.waddr = wa_q;
  assign bus.wdata = wd_q;
  assign bus.raddr = sub_q;
endmodule

/* include/afc_pkg.sv */
// Constants, types and helpers of the field-locked audio clock generator.
// Assumes a single 25 MHz system clock and subaddressed byte registers.
package afc_pkg;
  // Register subaddresses
  localparam logic [7:0] SUB_CPF_LO = 8'h30;
  localparam logic [7:0] SUB_CPF_MID = 8'h31;
  localparam logic [7:0] SUB_CPF_HI = 8'h32;
  localparam logic [7:0] SUB_NI_LO = 8'h34;
  localparam logic [7:0] SUB_NI_MID = 8'h35;
  localparam logic [7:0] SUB_NI_HI = 8'h36;
  localparam logic [7:0] SUB_BIT_DIV = 8'h38;
  localparam logic [7:0] SUB_CH_DIV = 8'h39;
  localparam logic [7:0] SUB_CTRL = 8'h3A;
  localparam logic [7:0] SUB_STATUS = 8'h3B;
  // Control bit positions
  localparam int CTRL_LOOP_OPEN = 3;
  localparam int CTRL_VREF_EXT = 2;
  localparam int CTRL_CH_PHASE = 1;
  localparam int CTRL_BIT_PHASE = 0;
  // Widths
  localparam int ACC_W = 23;
  localparam int CPF_W = 18;
  localparam int NI_W = 22;
  localparam int DIV_W = 6;
  // Reset value and strap sample count
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] STRAP_SAMPLE_CNT = 2'h2;
  // Bus device address, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
  } afc_i2c_st_t;

  // Byte lane of a multi-byte register
  function automatic logic [7:0] afc_byte(input logic [23:0] v, input logic [1:0] sel);
    logic [7:0] r;
    r = 8'h00;
    case (sel)
      2'h0: r = v[7:0];
      2'h1: r = v[15:8];
      default: r = v[23:16];
    endcase
    return r;
  endfunction
endpackage

/* include/afc_reg_if.sv */
// Byte register access between the serial bus slave and the register file.
// Assumes both ends run on the same clock.
interface afc_reg_if;
  logic wr_stb;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport slave (output wr_stb, output waddr, output wdata, output raddr, input rdata);
  modport regs (input wr_stb, input waddr, input wdata, input raddr, output rdata);
endinterface

/* tb/afc_audio_sink.sv */
// Audio clock consumer model: feeds the divider input pin and counts clock edges.
// Assumes the generator clocks are registers on clock_i; counts clear on clr_i.
module afc_audio_sink #(
  parameter int HALF = 8
) (
  // Clock and control
  input wire logic clock_i,
  input wire logic clr_i,
  input wire logic loop_back_i,
  input wire logic bit_phase_i,
  input wire logic ch_phase_i,
  // Generator clocks
  input wire logic master_i,
  input wire logic bit_clk_i,
  input wire logic ch_clk_i,
  output logic div_clk_o,
  // Edge counts
  output int master_rise_o,
  output int bit_tog_o,
  output int ch_tog_o,
  output int phase_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic own_clk = 1'b0;
  logic m_q = 1'b0;
  logic b_q = 1'b0;
  logic c_q = 1'b0;
  int cnt = 0;
  assign div_clk_o = loop_back_i ? master_i : own_clk;
  // Own source is slow enough that its level still shows the edge taken
  wire logic bit_bad = !loop_back_i && (bit_clk_i !== b_q) && (div_clk_o !== bit_phase_i);
  wire logic ch_bad = (ch_clk_i !== c_q) && (bit_clk_i !== ch_phase_i);
  always @(posedge clock_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      own_clk <= ~own_clk;
    end
    m_q <= master_i;
    b_q <= bit_clk_i;
    c_q <= ch_clk_i;
    if (clr_i) begin
      master_rise_o <= 0;
      bit_tog_o <= 0;
      ch_tog_o <= 0;
      phase_err_o <= 0;
    end else begin
      master_rise_o <= master_rise_o + int'(master_i && !m_q);
      bit_tog_o <= bit_tog_o + int'(bit_clk_i !== b_q);
      ch_tog_o <= ch_tog_o + int'(ch_clk_i !== c_q);
      phase_err_o <= phase_err_o + int'(bit_bad) + int'(ch_bad);
    end
  end
endmodule

/* tb/field_locked_audio_clock_gen_tb_top.sv */
// Self-checking bench of the audio clock generator, driven over its serial bus.
// Assumes the bench drives the strap pin and the bus line has a pull-up.
module field_locked_audio_clock_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SUBS [10] = '{afc_pkg::SUB_CPF_LO, afc_pkg::SUB_CPF_MID,
    afc_pkg::SUB_CPF_HI, afc_pkg::SUB_NI_LO, afc_pkg::SUB_NI_MID, afc_pkg::SUB_NI_HI,
    afc_pkg::SUB_BIT_DIV, afc_pkg::SUB_CH_DIV, afc_pkg::SUB_CTRL, 8'h33};
  localparam logic [7:0] MASKS [10] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F,
    8'h3F, 8'h0F, 8'h00};
  logic clock_i = 1'b0;
  logic rst_n_i;
  logic scl;
  logic sda_drv;
  logic sda_o;
  logic sda_oe_n;
  logic fref_int;
  logic fref_ext;
  logic div_clk;
  logic master;
  logic bitc;
  logic chc;
  logic clr;
  logic loop_back;
  logic bph;
  logic cph;
  logic strap;
  int master_rise;
  int bit_tog;
  int ch_tog;
  int phase_err;
  int errors = 0;
  int check_count = 0;
  wire logic sda_line = (!sda_oe_n && !sda_o) ? 1'b0 : sda_drv;

  always #20 clock_i = ~clock_i;

  afc_clock_gen dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n),
    .field_ref_int_i(fref_int),
    .field_ref_ext_i(fref_ext),
    .xtal_sel_strap_i(strap),
    .divider_clock_in_i(div_clk),
    .synth_master_clock_out_o(master),
    .serial_bit_clock_out_o(bitc),
    .channel_select_clock_out_o(chc)
  );

  afc_audio_sink sink (
    .clock_i(clock_i),
    .clr_i(clr),
    .loop_back_i(loop_back),
    .bit_phase_i(bph),
    .ch_phase_i(cph),
    .master_i(master),
    .bit_clk_i(bitc),
    .ch_clk_i(chc),
    .div_clk_o(div_clk),
    .master_rise_o(master_rise),
    .bit_tog_o(bit_tog),
    .ch_tog_o(ch_tog),
    .phase_err_o(phase_err)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Start and repeated start alike: sda falls while scl is high
  task automatic bus_start;
    sda_drv = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(6);
  endtask

  task automatic bus_stop;
    sda_drv = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b1;
    tick(6);
  endtask

  task automatic bus_bit(input logic b, output logic r);
    sda_drv = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda_line;
    scl = 1'b0;
    tick(6);
  endtask

  task automatic bus_byte(input logic [7:0] w, input logic mack, output logic [7:0] r,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bus_bit(w[i], r[i]);
    end
    bus_bit(mack, ack);
  endtask

  task automatic reg_wr(input logic [7:0] sub, input logic [7:0] val);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    bus_start;
    bus_byte({afc_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, a0);
    bus_byte(sub, 1'b1, r, a1);
    bus_byte(val, 1'b1, r, a2);
    bus_stop;
    check_byte("write ack", 8'h00, {5'h00, a0, a1, a2});
  endtask

  task automatic reg_rd(input logic [7:0] sub, output logic [7:0] val);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic nack;
    bus_start;
    bus_byte({afc_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, a0);
    bus_byte(sub, 1'b1, r, a1);
    bus_start;
    bus_byte({afc_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r, a2);
    bus_byte(8'hFF, 1'b1, val, nack);
    bus_stop;
    check_byte("read ack", 8'h00, {5'h00, a0, a1, a2});
  endtask

  task automatic measure(input int n);
    tick(64);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(n);
  endtask

  task automatic set_inc(input logic [23:0] v);
    reg_wr(afc_pkg::SUB_NI_LO, v[7:0]);
    reg_wr(afc_pkg::SUB_NI_MID, v[15:8]);
    reg_wr(afc_pkg::SUB_NI_HI, v[23:16]);
  endtask

  task automatic fields(input logic ext, input int n, input int gap);
    repeat (n) begin
      if (ext) begin
        fref_ext = 1'b1;
      end else begin
        fref_int = 1'b1;
      end
      tick(10);
      fref_ext = 1'b0;
      fref_int = 1'b0;
      tick(gap);
    end
  endtask

  task automatic test_regs;
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      reg_rd(SUBS[i], d);
      check_byte("reset value", 8'h00, d);
      reg_wr(SUBS[i], 8'hFF);
      reg_rd(SUBS[i], d);
      check_byte("readback", MASKS[i], d);
    end
    reg_wr(afc_pkg::SUB_STATUS, 8'hFF);
    reg_rd(afc_pkg::SUB_STATUS, d);
    check_byte("status", 8'h02, d);
    $display("register test done");
  endtask

  // Own source: 64 rises and 64 falls in each 1024-cycle window
  task automatic run_div(input logic [7:0] bit_clock_div_value, input logic [7:0] cdiv,
                         input logic [7:0] ctrl, input int btog, input int ctog);
    reg_wr(afc_pkg::SUB_BIT_DIV, bit_clock_div_value);
    reg_wr(afc_pkg::SUB_CH_DIV, cdiv);
    reg_wr(afc_pkg::SUB_CTRL, ctrl);
    bph = ctrl[0];
    cph = ctrl[1];
    measure(1024);
    check_range("bit toggles", btog - 1, btog + 1, bit_tog);
    check_range("channel toggles", ctog - 1, ctog + 1, ch_tog);
    check_range("edge phase errors", 0, 0, phase_err);
  endtask

  task automatic test_dividers;
    run_div(8'h01, 8'h02, 8'h03, 32, 8);
    run_div(8'h03, 8'h01, 8'h00, 16, 8);
    $display("divider test done");
  endtask

  task automatic test_synth;
    reg_wr(afc_pkg::SUB_CTRL, 8'h08);
    set_inc(24'h30FBCE);
    measure(4096);
    check_range("master rises", 1566, 1569, master_rise);
    set_inc(24'h100000);
    loop_back = 1'b1;
    measure(1000);
    check_range("master rises", 124, 126, master_rise);
    check_range("looped bit toggles", 30, 32, bit_tog);
    loop_back = 1'b0;
    $display("synthesizer test done");
  endtask

  // Master period is exactly 8 cycles, so a 1000-cycle field holds 125
  task automatic test_lock;
    logic [7:0] d;
    reg_wr(afc_pkg::SUB_CPF_LO, 8'h7D);
    reg_wr(afc_pkg::SUB_CPF_MID, 8'h00);
    reg_wr(afc_pkg::SUB_CPF_HI, 8'h00);
    reg_wr(afc_pkg::SUB_CTRL, 8'h04);
    fields(1'b1, 4, 990);
    reg_rd(afc_pkg::SUB_STATUS, d);
    check_byte("lock on target", 8'h03, d);
    fields(1'b0, 4, 490);
    reg_rd(afc_pkg::SUB_STATUS, d);
    check_byte("unselected reference", 8'h03, d);
    reg_wr(afc_pkg::SUB_CPF_LO, 8'hC8);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    fields(1'b1, 3, 990);
    check_range("master over fields", 373, 377, master_rise);
    reg_rd(afc_pkg::SUB_STATUS, d);
    check_byte("lock off target", 8'h02, d);
    $display("lock test done");
  endtask

  // Mid-run reset with the strap low, then a foreign device address
  task automatic test_strap;
    logic [7:0] d;
    logic a;
    strap = 1'b0;
    rst_n_i = 1'b0;
    tick(4);
    rst_n_i = 1'b1;
    tick(8);
    reg_rd(afc_pkg::SUB_STATUS, d);
    check_byte("strap low", 8'h00, d);
    reg_rd(afc_pkg::SUB_CPF_LO, d);
    check_byte("target after reset", 8'h00, d);
    bus_start;
    bus_byte({~afc_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d, a);
    bus_stop;
    check_byte("foreign address ack", 8'h01, {7'h00, a});
    $display("strap test done");
  endtask

  initial begin
    repeat (80000) @(posedge clock_i);
    errors++;
    complete_run;
  end

  initial begin
    rst_n_i = 1'b0;
    scl = 1'b1;
    sda_drv = 1'b1;
    fref_int = 1'b0;
    fref_ext = 1'b0;
    clr = 1'b0;
    loop_back = 1'b0;
    bph = 1'b0;
    cph = 1'b0;
    strap = 1'b1;
    tick(16);
    rst_n_i = 1'b1;
    tick(4);
    test_regs;
    test_dividers;
    test_synth;
    test_lock;
    test_strap;
    complete_run;
  end
endmodule
